// *** logic/fec_top.sv ***
// Frequency error counter: reference dividers, gated counter and meter code.
//
// Notes on behaviour
// - Divide the 10 MHz reference down to a 500 kHz high-loop reference.
// - Derive 1 MHz, then 10 kHz, 1 kHz, 100 Hz and 10 Hz timebases.
// - 100 Hz feeds the low loop; 1 kHz feeds carrier loop and tone.
// - Range selection picks the timebase that sets the sampling window length.
// - Carrier mode loads a range-dependent starting count before sampling.
// - Carrier mode adds one per input cycle seen inside the window.
// - Ending count of exactly 128 gives the null converter code.
// - Counts above 128 read more positive, below less, proportional to distance.
// - Audio mode preloads 128 so the count starts at zero error; the meter holds its last reading.
// - Audio mode first counts the unknown tone upward for one window.
// - Then the reference tone counts downward for an equal window.
// - Audio result above 128 means tone high, below means tone low.
// - Five 4-bit stages; low two feed converter, upper three the range detector.
// - Converter spans 0 to 255, negative at 0, zero at 128, positive at 255.
// - Low stages wrap past 255 carrying into overflow stages preset by range.
// - On scale only when overflow stages end at zero, else full-scale over/under.
`timescale 1ns/10ps
`default_nettype none

module fec_top
  import fec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       audio_mode,
  input  wire fec_range_t range_sel,
  input  wire fec_sig_t   sig_in,
  output var  fec_refs_t  refs,
  output var  fec_res_t   result
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic tb_pick(fec_range_t r, logic [3:0] tb);
    tb_pick = tb[r];
  endfunction : tb_pick

  function automatic logic [CNT_W-1:0] car_preload(fec_range_t r);
    unique case (r)
      FEC_RNG_10:  car_preload = CAR_PRE_10;
      FEC_RNG_100: car_preload = CAR_PRE_100;
      FEC_RNG_1K:  car_preload = CAR_PRE_1K;
      FEC_RNG_10K: car_preload = CAR_PRE_10K;
    endcase
  endfunction : car_preload

  fec_state_t s_q;
  fec_state_t s_d;
  logic       tick;
  logic       finish;
  logic       car_edge;
  logic       unk_edge;
  logic       tone_edge;
  logic [CNT_W-1:0] cnt_n;
  logic [CNT_W-DAC_W-1:0] ovf;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic       carry;
    s_d       = s_q;
    carry     = 1'b0;
    tick      = tb_pick(s_q.rng, s_q.refs.tb);
    car_edge  = sig_in.car & ~s_q.prev.car;
    unk_edge  = sig_in.unk & ~s_q.prev.unk;
    tone_edge = sig_in.tone & ~s_q.prev.tone;
    s_d.prev  = sig_in;
    finish    = 1'b0;

    // The reference is the clock halved; the high-loop output comes
    // straight from the clock count so it needs no extra stage.
    s_d.refs.hl_ref = (s_q.d_hl == DIV_HL_LAST);
    s_d.d_hl        = s_d.refs.hl_ref ? 6'h00 : s_q.d_hl + 6'h01;
    s_d.dig_tick    = (s_q.d_dig == DIV_DIG_LAST);
    s_d.d_dig       = s_d.dig_tick ? 6'h00 : s_q.d_dig + 6'h01;

    // Decade chain from the 1 MHz enable: stage k ticks at 100 kHz / 10^k.
    carry = s_q.dig_tick;
    for (int k = 0; k < N_DEC; k++) begin
      if (carry) begin
        s_d.dec[k] = (s_q.dec[k] == DEC_LAST) ? 4'h0 : s_q.dec[k] + 4'h1;
      end
      carry = carry && (s_q.dec[k] == DEC_LAST);
      if (k >= 1) begin
        s_d.refs.tb[N_DEC-1-k] = carry;
      end
    end
    s_d.refs.ll_ref  = s_d.refs.tb[FEC_RNG_100];
    s_d.refs.khz_ref = s_d.refs.tb[FEC_RNG_1K];

    // Plain binary counting carries between 4-bit stages exactly as a
    // cascade would; a borrow below zero rolls the overflow stages to ones.
    cnt_n = s_q.cnt;
    if (s_q.st == FEC_UP) begin
      cnt_n = s_q.audio ? s_q.cnt + CNT_W'(unk_edge)
                        : s_q.cnt + CNT_W'(car_edge);
    end else if (s_q.st == FEC_DOWN) begin
      cnt_n = s_q.cnt - CNT_W'(tone_edge);
    end
    s_d.cnt = cnt_n;
    ovf     = cnt_n[CNT_W-1:DAC_W];

    s_d.res.done = 1'b0;
    unique case (s_q.st)
      FEC_IDLE: begin
        if (start) begin
          s_d.st    = FEC_ARM;
          s_d.rng   = range_sel;
          s_d.audio = audio_mode;
          s_d.cnt   = audio_mode ? NULL_COUNT : car_preload(range_sel);
        end
      end
      FEC_ARM: begin
        if (tick) begin
          s_d.st = FEC_UP;
        end
      end
      FEC_UP: begin
        if (tick) begin
          if (s_q.audio) begin
            s_d.st = FEC_DOWN;
          end else begin
            finish = 1'b1;
          end
        end
      end
      FEC_DOWN: begin
        if (tick) begin
          finish = 1'b1;
        end
      end
    endcase
    s_d.res.busy = (s_d.st != FEC_IDLE);

    // The meter code only moves when a measurement ends, so a reading
    // stays put while the next one is preloaded and gated.
    if (finish) begin
      s_d.st        = FEC_IDLE;
      s_d.res.busy  = 1'b0;
      s_d.res.done  = 1'b1;
      s_d.res.over  = (ovf != '0) && !ovf[CNT_W-DAC_W-1];
      s_d.res.under = ovf[CNT_W-DAC_W-1];
      if (ovf == '0) begin
        s_d.res.meter = cnt_n[DAC_W-1:0];
      end else if (ovf[CNT_W-DAC_W-1]) begin
        s_d.res.meter = FULL_NEG;
      end else begin
        s_d.res.meter = FULL_POS;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q           <= '0;
      s_q.st        <= FEC_IDLE;
      s_q.cnt       <= NULL_COUNT;
      s_q.res.meter <= NULL_CODE;
    end else begin
      s_q <= s_d;
    end
  end

  assign refs   = s_q.refs;
  assign result = s_q.res;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_accept_audio;
    s_q.st == FEC_IDLE && start && audio_mode;
  endsequence

  sequence seq_accept_car;
    s_q.st == FEC_IDLE && start && !audio_mode;
  endsequence

  sequence seq_up_end;
    s_q.st == FEC_UP && tick;
  endsequence

  sequence seq_down_end;
    s_q.st == FEC_DOWN && tick;
  endsequence

  sequence seq_car_wrap;
    s_q.st == FEC_UP && !s_q.audio && car_edge && s_q.cnt[DAC_W-1:0] == FULL_POS;
  endsequence

  a_hl_ref_period: assert property (refs.hl_ref |-> ##40 refs.hl_ref)
    else $error("High-loop reference period is not 40 cycles.");

  a_tb_nesting: assert property (refs.tb[0] |-> refs.tb[1] && refs.tb[2] && refs.tb[3])
    else $error("Slow timebase tick not aligned with faster ticks.");

  a_ll_ref_link: assert property (refs.ll_ref |-> refs.khz_ref && refs.tb[1])
    else $error("Low-loop reference not on the 100 Hz tick.");

  a_window_start: assert property (s_q.st == FEC_ARM && tick |=> s_q.st == FEC_UP)
    else $error("Window did not open on the selected timebase tick.");

  a_car_preload: assert property (seq_accept_car |=> s_q.cnt == car_preload($past(range_sel)))
    else $error("Carrier starting count is wrong.");

  a_car_count: assert property (s_q.st == FEC_UP && !s_q.audio && car_edge
      |=> s_q.cnt == $past(s_q.cnt) + 20'h00001)
    else $error("Carrier edge did not increment the counter.");

  a_audio_preload: assert property (seq_accept_audio |=> s_q.st == FEC_ARM
      && s_q.cnt == NULL_COUNT && result.meter == $past(result.meter))
    else $error("Audio preload is not the null count.");

  a_audio_seq: assert property (seq_up_end ##0 s_q.audio |=> s_q.st == FEC_DOWN)
    else $error("Audio up window not followed by down window.");

  a_tone_down: assert property (s_q.st == FEC_DOWN && tone_edge
      |=> s_q.cnt == $past(s_q.cnt) - 20'h00001)
    else $error("Reference tone edge did not decrement the counter.");

  a_on_scale: assert property (result.done && !result.over && !result.under
      |-> result.meter == s_q.cnt[DAC_W-1:0] && s_q.cnt[CNT_W-1:DAC_W] == '0)
    else $error("On-scale meter code differs from final count.");

  a_full_scale: assert property (result.done && result.over |-> result.meter == FULL_POS)
    else $error("Over-range did not force full positive scale.");

  a_hold_result: assert property (!result.done |-> $stable(result.meter))
    else $error("Meter code changed outside the end of a measurement.");

  // ---------------------------------------------------------------
  // Reference, window, counting and result checks
  // ---------------------------------------------------------------
  a_hl_pulse_width: assert property (refs.hl_ref |=> !refs.hl_ref)
    else $error("High-loop reference pulse is longer than one cycle.");

  a_tb_pulse_width: assert property (refs.tb[3] |=> !refs.tb[3])
    else $error("Fast timebase pulse is longer than one cycle.");

  a_khz_on_tick: assert property (refs.khz_ref |-> refs.tb[3])
    else $error("Kilohertz reference not aligned with the fast timebase.");

  a_busy_start: assert property (s_q.st == FEC_IDLE && start
      |=> result.busy && !result.done)
    else $error("Accepted start did not raise busy.");

  a_start_refused: assert property (s_q.st != FEC_IDLE && start
      |=> s_q.rng == $past(s_q.rng) && s_q.audio == $past(s_q.audio))
    else $error("Start while busy changed the latched range or mode.");

  a_done_idle: assert property (result.done |-> !result.busy)
    else $error("Busy still set in the result cycle.");

  a_arm_no_count: assert property (s_q.st == FEC_ARM |=> s_q.cnt == $past(s_q.cnt))
    else $error("Counter moved before the sampling window opened.");

  a_car_close: assert property (seq_up_end ##0 !s_q.audio
      |=> result.done && s_q.st == FEC_IDLE)
    else $error("Carrier window end did not produce a result.");

  a_unk_count: assert property (s_q.st == FEC_UP && s_q.audio && unk_edge
      |=> s_q.cnt == $past(s_q.cnt) + 20'h00001)
    else $error("Unknown tone edge did not increment the counter.");

  a_up_no_tone: assert property (s_q.st == FEC_UP && s_q.audio && !unk_edge
      |=> s_q.cnt == $past(s_q.cnt))
    else $error("Counter moved without an unknown tone edge.");

  a_down_no_unk: assert property (s_q.st == FEC_DOWN && !tone_edge
      |=> s_q.cnt == $past(s_q.cnt))
    else $error("Counter moved without a reference tone edge.");

  a_down_close: assert property (seq_down_end |=> result.done && s_q.st == FEC_IDLE)
    else $error("Down window end did not produce a result.");

  a_car_wrap: assert property (seq_car_wrap
      |=> s_q.cnt[DAC_W-1:0] == 8'h00
      && s_q.cnt[CNT_W-1:DAC_W] == $past(s_q.cnt[CNT_W-1:DAC_W]) + 12'h001)
    else $error("Converter stages did not wrap with a carry into the overflow stages.");

  a_idle_no_count: assert property (s_q.st == FEC_IDLE && !start
      |=> s_q.cnt == $past(s_q.cnt))
    else $error("Counter moved while idle.");

  a_done_pulse: assert property (result.done |=> !result.done)
    else $error("Result strobe lasted more than one cycle.");

  a_null_code: assert property (result.done && s_q.cnt == NULL_COUNT
      |-> result.meter == NULL_CODE && !result.over && !result.under)
    else $error("Null count did not give the null code.");

  a_under_scale: assert property (result.done && result.under
      |-> result.meter == FULL_NEG && !result.over)
    else $error("Under-range did not force full negative scale.");

endmodule : fec_top

`default_nettype wire

// *** include/fec_pkg.sv ***
// Package of constants and types for the frequency error counter.
package fec_pkg;

  // ---------------------------------------------------------------
  // Clock and divider figures
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned REF_HZ     = 10_000_000;
  localparam int unsigned HL_REF_HZ  = 500_000;
  localparam int unsigned DIG_REF_HZ = 1_000_000;
  localparam int unsigned DIV_HL     = CLK_HZ / HL_REF_HZ;
  localparam int unsigned DIV_DIG    = CLK_HZ / DIG_REF_HZ;
  localparam int unsigned DEC_RATIO  = 10;
  localparam int unsigned N_DEC      = 5;
  localparam logic [5:0]  DIV_HL_LAST  = 6'(DIV_HL - 1);
  localparam logic [5:0]  DIV_DIG_LAST = 6'(DIV_DIG - 1);
  localparam logic [3:0]  DEC_LAST     = 4'(DEC_RATIO - 1);

  // ---------------------------------------------------------------
  // Counter layout
  // ---------------------------------------------------------------
  localparam int unsigned STAGE_W = 4;
  localparam int unsigned N_STAGE = 5;
  localparam int unsigned CNT_W   = STAGE_W * N_STAGE;
  localparam int unsigned DAC_W   = 2 * STAGE_W;
  localparam logic [CNT_W-1:0] NULL_COUNT = 20'h00080;
  localparam logic [DAC_W-1:0] NULL_CODE  = 8'h80;
  localparam logic [DAC_W-1:0] FULL_POS   = 8'hff;
  localparam logic [DAC_W-1:0] FULL_NEG   = 8'h00;

  // Nominal carrier count rate after the outside prescaler.
  localparam longint CAR_NOM_HZ = 1_000_000;
  localparam longint TB_HZ_10   = 10;
  localparam longint TB_HZ_100  = 100;
  localparam longint TB_HZ_1K   = 1_000;
  localparam longint TB_HZ_10K  = 10_000;

  // Starting counts: null count less the cycles expected in one window.
  localparam logic [CNT_W-1:0] CAR_PRE_10  = CNT_W'(128 - CAR_NOM_HZ / TB_HZ_10);
  localparam logic [CNT_W-1:0] CAR_PRE_100 = CNT_W'(128 - CAR_NOM_HZ / TB_HZ_100);
  localparam logic [CNT_W-1:0] CAR_PRE_1K  = CNT_W'(128 - CAR_NOM_HZ / TB_HZ_1K);
  localparam logic [CNT_W-1:0] CAR_PRE_10K = CNT_W'(128 - CAR_NOM_HZ / TB_HZ_10K);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FEC_RNG_10  = 2'h0,
    FEC_RNG_100 = 2'h1,
    FEC_RNG_1K  = 2'h2,
    FEC_RNG_10K = 2'h3
  } fec_range_t;

  typedef enum logic [1:0] {FEC_IDLE, FEC_ARM, FEC_UP, FEC_DOWN} fec_fsm_t;

  typedef struct packed {
    logic car;
    logic unk;
    logic tone;
  } fec_sig_t;

  typedef struct packed {
    logic             hl_ref;
    logic             ll_ref;
    logic             khz_ref;
    logic [3:0]       tb;
  } fec_refs_t;

  typedef struct packed {
    logic [DAC_W-1:0] meter;
    logic             over;
    logic             under;
    logic             done;
    logic             busy;
  } fec_res_t;

  typedef struct packed {
    fec_fsm_t               st;
    logic [5:0]             d_hl;
    logic [5:0]             d_dig;
    logic [N_DEC-1:0][3:0]  dec;
    logic                   dig_tick;
    fec_refs_t              refs;
    fec_range_t             rng;
    logic                   audio;
    logic [CNT_W-1:0]       cnt;
    fec_sig_t               prev;
    fec_res_t               res;
  } fec_state_t;

endpackage : fec_pkg

// *** tb/fec_src_model.sv ***
// Behavioural model of the carrier and tone sources that feed the counter.
`timescale 1ns/10ps
`default_nettype none

module fec_src_model
  import fec_pkg::*;
(
  input  wire logic     clk,
  output var  fec_sig_t sig
);
  initial begin
    sig = '0;
  end

  // Each pulse is two cycles high and two low, so that a synchronous edge detector sees it.
  task automatic emit(input logic [1:0] line, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (line == 2'h0) sig.car = 1'b1;
      else if (line == 2'h1) sig.unk = 1'b1;
      else sig.tone = 1'b1;
      repeat (2) @(negedge clk);
      sig = '0;
      @(negedge clk);
    end
  endtask : emit
endmodule : fec_src_model
`default_nettype wire

// *** tb/fec_top_tb_top.sv ***
// Self-checking testbench of the frequency error counter.
`timescale 1ns/10ps
`default_nettype none

module fec_top_tb_top
  import fec_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       start;
  logic       audio_mode;
  fec_range_t range_sel;
  fec_sig_t   sig_in;
  fec_refs_t  refs;
  fec_res_t   result;
  int         n_mismatch;
  int         total_checks;
  int         ref_bad;

  fec_top fec_top_inst (.clk(clk), .rst(rst), .start(start), .audio_mode(audio_mode),
                        .range_sel(range_sel), .sig_in(sig_in), .refs(refs), .result(result));
  fec_src_model fec_src_model_inst (.clk(clk), .sig(sig_in));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Loop references must always mirror their timebase taps.
  always @(negedge clk) begin
    if (!rst && (refs.khz_ref !== refs.tb[2] || refs.ll_ref !== refs.tb[1])) ref_bad++;
  end

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Returns the cycles until bit idx of the reference bundle is seen high.
  task automatic wait_ref(input int idx, output int k);
    logic [6:0] r;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      r = refs;
      k++;
    end while (r[idx] !== 1'b1 && k < 30000);
  endtask : wait_ref

  task automatic check_refs();
    int k;
    wait_ref(6, k);
    wait_ref(6, k);
    chk("hl_ref period", 20'(k), 20'h00028);
    wait_ref(3, k);
    wait_ref(3, k);
    chk("tb10k period", 20'(k), 20'h007d0);
  endtask : check_refs

  // One measurement; bump tries a start while busy, which must be ignored.
  task automatic measure(input logic aud, input fec_range_t rg, input int n_up, input int n_dn,
                         input logic [7:0] e_m, input logic e_ov, input logic e_un,
                         input logic bump);
    int k;
    logic [7:0] held;
    @(negedge clk);
    held = result.meter;
    start = 1'b1;
    audio_mode = aud;
    range_sel = rg;
    @(negedge clk);
    start = 1'b0;
    repeat (2) @(negedge clk);
    wait_ref(int'(rg), k);
    repeat (3) @(negedge clk);
    fec_src_model_inst.emit(aud ? 2'h1 : 2'h0, n_up);
    if (aud) begin
      wait_ref(int'(rg), k);
      repeat (3) @(negedge clk);
      fec_src_model_inst.emit(2'h2, n_dn);
    end
    if (bump) begin
      start = 1'b1;
      audio_mode = 1'b1;
      @(negedge clk);
      start = 1'b0;
    end
    chk("busy", 20'(result.busy), 20'h00001);
    chk("meter held", 20'(result.meter), 20'(held));
    k = 0;
    while (result.done !== 1'b1 && k < 50000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("done seen", 20'(k < 50000), 20'h00001);
    chk("busy idle", 20'(result.busy), 20'h00000);
    chk("meter", 20'(result.meter), 20'(e_m));
    chk("over", 20'(result.over), 20'(e_ov));
    chk("under", 20'(result.under), 20'(e_un));
  endtask : measure

  // Carrier readings around the null count, to the top of scale and past it.
  task automatic run_carrier();
    // Range 3 carrier preload is 0x1c: 100 edges land on the null count.
    measure(1'b0, FEC_RNG_10K, 100, 0, 8'h80, 1'b0, 1'b0, 1'b0);
    measure(1'b0, FEC_RNG_10K, 150, 0, 8'hb2, 1'b0, 1'b0, 1'b1);
    measure(1'b0, FEC_RNG_10K, 50, 0, 8'h4e, 1'b0, 1'b0, 1'b0);
    measure(1'b0, FEC_RNG_10K, 227, 0, 8'hff, 1'b0, 1'b0, 1'b0);
    measure(1'b0, FEC_RNG_10K, 228, 0, 8'hff, 1'b1, 1'b0, 1'b0);
  endtask : run_carrier

  // Audio readings: equal, higher and lower tones, then both range limits.
  task automatic run_audio();
    measure(1'b1, FEC_RNG_10K, 10, 10, 8'h80, 1'b0, 1'b0, 1'b0);
    measure(1'b1, FEC_RNG_10K, 40, 25, 8'h8f, 1'b0, 1'b0, 1'b0);
    measure(1'b1, FEC_RNG_10K, 5, 20, 8'h71, 1'b0, 1'b0, 1'b0);
    measure(1'b1, FEC_RNG_10K, 0, 129, 8'h00, 1'b0, 1'b1, 1'b0);
    measure(1'b1, FEC_RNG_10K, 130, 2, 8'hff, 1'b1, 1'b0, 1'b0);
  endtask : run_audio

  // The 1 kHz window is ten times longer, so 1000 edges are needed for null.
  task automatic run_long_window();
    measure(1'b0, FEC_RNG_1K, 1000, 0, 8'h80, 1'b0, 1'b0, 1'b0);
  endtask : run_long_window

  initial begin
    rst = 1'b1;
    start = 1'b0;
    audio_mode = 1'b0;
    range_sel = FEC_RNG_10K;
    n_mismatch = 0;
    total_checks = 0;
    ref_bad = 0;
    repeat (8) @(negedge clk);
    chk("reset result", 20'(result), 20'({NULL_CODE, 4'h0}));
    chk("reset refs", 20'(refs), 20'h00000);
    rst = 1'b0;
    check_refs();
    run_carrier();
    run_audio();
    run_long_window();
    chk("loop refs", 20'(ref_bad), 20'h00000);
    results();
  end

  initial begin
    // The tests need about 80,000 cycles; the limit allows 90,000.
    #4500000;
    n_mismatch++;
    results();
  end
endmodule : fec_top_tb_top
`default_nettype wire
